/* design/dcd_pkg.sv */
// Shared constants and types for the driver chain datagram RAM and its sequencer
package dcd_pkg;
    // ****************************************************************
    // Memory geometry
    // ****************************************************************
    localparam int CELL_W     = 6;
    localparam int CODE_W     = 5;
    localparam int NUM_CELLS  = 128;
    localparam int CELL_AW    = 7;
    localparam int HOST_AW    = 6;
    localparam int BUS_AW     = 7;
    localparam int DATA_W     = 12;
    localparam int PTR_W      = 6;
    localparam int NXM_BIT    = 5;
    localparam int SELECT_BIT = 6;

    localparam logic [CELL_AW-1:0] TABLE_BASE = 7'h40;
    localparam logic [PTR_W-1:0]   PTR_FIRST  = 6'h00;

    // ****************************************************************
    // Motors and microstep expansion
    // ****************************************************************
    localparam int NUM_MOTORS = 3;
    localparam int MOTOR_W    = 2;
    localparam int PHASE_W    = 8;
    localparam int RES_W      = 3;
    localparam int TAB_W      = 6;

    localparam logic [MOTOR_W-1:0] MOTOR_FIRST  = 2'h0;
    localparam logic [MOTOR_W-1:0] MOTOR_STEP   = 2'h1;
    localparam logic [PHASE_W-1:0] COIL_B_SHIFT = 8'h40;
    localparam logic [TAB_W-1:0]   TAB_LAST     = 6'h3F;

    // ****************************************************************
    // Own registers, reached with the select bit at 0
    // ****************************************************************
    localparam logic [HOST_AW-1:0] REG_CONTROL   = 6'h00;
    localparam logic [HOST_AW-1:0] REG_STATUS    = 6'h01;
    localparam int                 CTL_LDI_LSB   = 0;
    localparam int                 CTL_SEND_BIT  = 2;
    localparam int                 STS_BUSY_BIT  = 0;
    localparam int                 STS_MOTOR_LSB = 1;
    localparam int                 STS_PTR_LSB   = 3;
    localparam logic [MOTOR_W-1:0] LDI_RESET     = 2'h2;

    // ****************************************************************
    // Selector codes
    // ****************************************************************
    localparam logic [2:0]        SUB_PHASE = 3'h6;
    localparam logic [2:0]        SUB_DECAY = 3'h7;
    localparam logic [CODE_W-1:0] SIG_ZERO  = 5'h10;
    localparam logic [CODE_W-1:0] SIG_ONE   = 5'h11;
    localparam logic [CODE_W-1:0] SIG_DIR   = 5'h12;
    localparam logic [CODE_W-1:0] SIG_STEP  = 5'h13;

    typedef struct packed {
        logic [PHASE_W-1:0] microstep;
        logic [RES_W-1:0]   resolution;
        logic               fastDecayA;
        logic               fastDecayB;
        logic               direction;
        logic               step;
    } motor_in_t;

    typedef struct packed {
        logic [TAB_W-1:0] dacA;
        logic [TAB_W-1:0] dacB;
        logic             phaseA;
        logic             phaseB;
        logic             fastDecayA;
        logic             fastDecayB;
        logic             direction;
        logic             step;
    } motor_snap_t;
endpackage

/* design/link_serializer.sv */
// Link-clock side: shifts one handed-over bit per request onto the driver chain
`timescale 1ns/1ps
module link_serializer
(
    input  wire logic linkClk,       // Link clock
    input  wire logic arst_n,        // Async reset, active low
    input  wire logic bitReqToggle,  // Toggles once per bit offered
    input  wire logic bitData,       // Bit value, stable while pending
    input  wire logic bitLast,       // Bit closes the frame
    output logic      bitAckToggle,  // Toggles once per bit sent
    output logic      driverSck,     // Serial clock to chain
    output logic      driverSdo,     // Serial data to chain
    output logic      driverCsN      // Chain select, active low
);
    import dcd_pkg::*;

    typedef enum logic [2:0]
    {
        L_IDLE = 3'b001,
        L_LOW  = 3'b010,
        L_HIGH = 3'b100
    } link_state_t;

    link_state_t state;
    link_state_t next_state;
    logic        reqS1;
    logic        reqS2;
    logic        reqS3;
    logic        reqSeen;
    logic        next_reqSeen;
    logic        pendLast;
    logic        next_pendLast;
    logic        next_bitAckToggle;
    logic        next_driverSck;
    logic        next_driverSdo;
    logic        next_driverCsN;

    // ****************************************************************
    // Bit sequencing
    // ****************************************************************
    always_comb
    begin
        next_state        = state;
        next_reqSeen      = reqSeen;
        next_pendLast     = pendLast;
        next_bitAckToggle = bitAckToggle;
        next_driverSck    = driverSck;
        next_driverSdo    = driverSdo;
        next_driverCsN    = driverCsN;
        unique case (state)
            L_IDLE:
            begin
                // A request counts only once the last two stages agree
                if ((reqS2 == reqS3) && (reqS3 != reqSeen))
                begin
                    next_reqSeen   = reqS3;
                    next_driverSdo = bitData;
                    next_pendLast  = bitLast;
                    next_driverCsN = 1'b0;
                    next_driverSck = 1'b0;
                    next_state     = L_LOW;
                end
            end
            L_LOW:
            begin
                next_driverSck = 1'b1;
                next_state     = L_HIGH;
            end
            L_HIGH:
            begin
                next_driverSck    = 1'b0;
                next_bitAckToggle = ~bitAckToggle;
                if (pendLast)
                begin
                    next_driverCsN = 1'b1;
                end
                next_state = L_IDLE;
            end
        endcase
    end

    always_ff @(posedge linkClk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state        <= L_IDLE;
            reqS1        <= 1'b0;
            reqS2        <= 1'b0;
            reqS3        <= 1'b0;
            reqSeen      <= 1'b0;
            pendLast     <= 1'b0;
            bitAckToggle <= 1'b0;
            driverSck    <= 1'b0;
            driverSdo    <= 1'b0;
            driverCsN    <= 1'b1;
        end
        else
        begin
            state        <= next_state;
            reqS1        <= bitReqToggle;
            reqS2        <= reqS1;
            reqS3        <= reqS2;
            reqSeen      <= next_reqSeen;
            pendLast     <= next_pendLast;
            bitAckToggle <= next_bitAckToggle;
            driverSck    <= next_driverSck;
            driverSdo    <= next_driverSdo;
            driverCsN    <= next_driverCsN;
        end
    end
endmodule

/* design/driver_chain_datagram_ram.sv */
// Configuration RAM, host access port and driver chain datagram sequencer
`timescale 1ns/1ps
module driver_chain_datagram_ram
(
    input  wire logic                                 mclk,         // System clock, 50 MHz
    input  wire logic                                 arst_n,       // Async reset, active low
    input  wire logic                                 linkClk,      // Driver chain link clock
    input  wire logic [dcd_pkg::BUS_AW-1:0]           addr,         // Select bit and pair address
    input  wire logic [dcd_pkg::DATA_W-1:0]           wdata,        // Write data
    input  wire logic                                 wr,           // Write strobe
    input  wire logic                                 rd,           // Read strobe
    output logic      [dcd_pkg::DATA_W-1:0]           rdata,        // Read data, cycle after rd
    input  wire logic                                 sendReq,      // Datagram demand pulse
    input  dcd_pkg::motor_in_t [dcd_pkg::NUM_MOTORS-1:0] motorIn,   // Sequencer outputs per motor
    output logic                                      busy,         // Datagram in progress
    output logic                                      driverSck,    // Serial clock to chain
    output logic                                      driverSdo,    // Serial data to chain
    output logic                                      driverCsN     // Chain select, active low
);
    import dcd_pkg::*;

    typedef enum logic [2:0]
    {
        S_IDLE  = 3'b001,
        S_FETCH = 3'b010,
        S_WAIT  = 3'b100
    } seq_state_t;

    logic [CELL_W-1:0]                    ram [NUM_CELLS];
    logic [DATA_W-1:0]                    next_rdata;
    logic [MOTOR_W-1:0]                   last_driver_index;
    logic [MOTOR_W-1:0]                   next_last_driver_index;
    logic                                 softSend;
    seq_state_t                           state;
    seq_state_t                           next_state;
    logic [PTR_W-1:0]                     ptr;
    logic [PTR_W-1:0]                     next_ptr;
    logic [MOTOR_W-1:0]                   motor;
    logic [MOTOR_W-1:0]                   next_motor;
    logic                                 curNxm;
    logic                                 next_curNxm;
    logic                                 bitData;
    logic                                 next_bitData;
    logic                                 bitLast;
    logic                                 next_bitLast;
    logic                                 reqToggle;
    logic                                 next_reqToggle;
    logic                                 ackToggle;
    logic                                 ackS1;
    logic                                 ackS2;
    logic                                 ackS3;
    logic                                 ackSeen;
    logic                                 next_ackSeen;
    motor_snap_t [NUM_MOTORS-1:0]         snap;
    motor_snap_t [NUM_MOTORS-1:0]         next_snap;
    motor_snap_t [NUM_MOTORS-1:0]         live;
    logic [CELL_W-1:0]                    fetchWord;
    motor_snap_t                          curSnap;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Folds a full-period phase onto the stored quarter wave
    function automatic logic [TAB_W-1:0] quarterIndex(input logic [PHASE_W-1:0] phase);
        logic [TAB_W-1:0] i;
        i = phase[TAB_W-1:0];
        quarterIndex = phase[TAB_W] ? (TAB_LAST - i) : i;
    endfunction

    function automatic logic selectSignal(input motor_snap_t s, input logic [CODE_W-1:0] code);
        logic [2:0] sub;
        sub          = code[2:0];
        selectSignal = 1'b0;
        if (!code[CODE_W-1])
        begin
            if (sub == SUB_PHASE)
                selectSignal = code[3] ? s.phaseB : s.phaseA;
            else if (sub == SUB_DECAY)
                selectSignal = code[3] ? s.fastDecayB : s.fastDecayA;
            else
                selectSignal = code[3] ? s.dacB[sub] : s.dacA[sub];
        end
        else if (code == SIG_ONE)
            selectSignal = 1'b1;
        else if (code == SIG_DIR)
            selectSignal = s.direction;
        else if (code == SIG_STEP)
            selectSignal = s.step;
        // Zero and the unused codes send a constant low
    endfunction

    // ****************************************************************
    // Host port
    // ****************************************************************
    assign softSend = wr && !addr[SELECT_BIT] && (addr[HOST_AW-1:0] == REG_CONTROL) && wdata[CTL_SEND_BIT];

    // Writes land a whole pair of six-bit cells per cycle, so a fetch sees old or new, never a mix
    always_ff @(posedge mclk)
    begin
        if (wr && addr[SELECT_BIT])
        begin
            ram[{addr[HOST_AW-1:0], 1'b1}] <= wdata[DATA_W-1:CELL_W];
            ram[{addr[HOST_AW-1:0], 1'b0}] <= wdata[CELL_W-1:0];
        end
    end

    always_comb
    begin
        next_rdata             = '0;
        next_last_driver_index = last_driver_index;
        if (wr && !addr[SELECT_BIT] && (addr[HOST_AW-1:0] == REG_CONTROL))
        begin
            next_last_driver_index = wdata[CTL_LDI_LSB +: MOTOR_W];
        end
        if (rd)
        begin
            if (addr[SELECT_BIT])
            begin
                next_rdata = {ram[{addr[HOST_AW-1:0], 1'b1}], ram[{addr[HOST_AW-1:0], 1'b0}]};
            end
            else if (addr[HOST_AW-1:0] == REG_CONTROL)
            begin
                next_rdata[CTL_LDI_LSB +: MOTOR_W] = last_driver_index;
            end
            else if (addr[HOST_AW-1:0] == REG_STATUS)
            begin
                next_rdata[STS_BUSY_BIT]             = busy;
                next_rdata[STS_MOTOR_LSB +: MOTOR_W] = motor;
                next_rdata[STS_PTR_LSB +: PTR_W]     = ptr;
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rdata             <= '0;
            last_driver_index <= LDI_RESET;
        end
        else
        begin
            rdata             <= next_rdata;
            last_driver_index <= next_last_driver_index;
        end
    end

    // ****************************************************************
    // Microstep expansion from the shared table
    // ****************************************************************
    genvar m;
    generate
        for (m = 0; m < NUM_MOTORS; m++)
        begin : g_motor
            logic [PHASE_W-1:0] phaseA;
            logic [PHASE_W-1:0] phaseB;
            // Coarser resolutions stride further through the same table
            assign phaseA = PHASE_W'(motorIn[m].microstep << motorIn[m].resolution);
            assign phaseB = phaseA + COIL_B_SHIFT;
            assign live[m].dacA       = ram[TABLE_BASE + CELL_AW'(quarterIndex(phaseA))];
            assign live[m].dacB       = ram[TABLE_BASE + CELL_AW'(quarterIndex(phaseB))];
            assign live[m].phaseA     = phaseA[PHASE_W-1];
            assign live[m].phaseB     = phaseB[PHASE_W-1];
            assign live[m].fastDecayA = motorIn[m].fastDecayA;
            assign live[m].fastDecayB = motorIn[m].fastDecayB;
            assign live[m].direction  = motorIn[m].direction;
            assign live[m].step       = motorIn[m].step;
        end
    endgenerate

    // ****************************************************************
    // Datagram sequencer
    // ****************************************************************
    assign busy      = (state != S_IDLE);
    assign fetchWord = ram[{1'b0, ptr}];
    // Indexes past the third motor read an all-zero snapshot, so only the one code sends high
    assign curSnap   = (motor < MOTOR_W'(NUM_MOTORS)) ? snap[motor] : '0;

    always_comb
    begin
        next_state     = state;
        next_ptr       = ptr;
        next_motor     = motor;
        next_curNxm    = curNxm;
        next_bitData   = bitData;
        next_bitLast   = bitLast;
        next_reqToggle = reqToggle;
        next_snap      = snap;
        next_ackSeen   = (ackS2 == ackS3) ? ackS3 : ackSeen;
        unique case (state)
            S_IDLE:
            begin
                if (sendReq || softSend)
                begin
                    next_snap  = live;
                    next_ptr   = PTR_FIRST;
                    next_motor = MOTOR_FIRST;
                    next_state = S_FETCH;
                end
            end
            S_FETCH:
            begin
                next_curNxm    = fetchWord[NXM_BIT];
                next_bitData   = selectSignal(curSnap, fetchWord[CODE_W-1:0]);
                next_bitLast   = fetchWord[NXM_BIT] && (motor == last_driver_index);
                next_reqToggle = ~reqToggle;
                next_state     = S_WAIT;
            end
            S_WAIT:
            begin
                if (ackSeen == reqToggle)
                begin
                    if (bitLast)
                    begin
                        next_motor = MOTOR_FIRST;
                        next_ptr   = PTR_FIRST;
                        next_state = S_IDLE;
                    end
                    else
                    begin
                        if (curNxm)
                        begin
                            next_motor = motor + MOTOR_STEP;
                        end
                        // The pointer wraps, so a table with no flag set keeps sending
                        next_ptr   = ptr + PTR_W'(1);
                        next_state = S_FETCH;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state     <= S_IDLE;
            ptr       <= PTR_FIRST;
            motor     <= MOTOR_FIRST;
            curNxm    <= 1'b0;
            bitData   <= 1'b0;
            bitLast   <= 1'b0;
            reqToggle <= 1'b0;
            snap      <= '0;
            ackS1     <= 1'b0;
            ackS2     <= 1'b0;
            ackS3     <= 1'b0;
            ackSeen   <= 1'b0;
        end
        else
        begin
            state     <= next_state;
            ptr       <= next_ptr;
            motor     <= next_motor;
            curNxm    <= next_curNxm;
            bitData   <= next_bitData;
            bitLast   <= next_bitLast;
            reqToggle <= next_reqToggle;
            snap      <= next_snap;
            ackS1     <= ackToggle;
            ackS2     <= ackS1;
            ackS3     <= ackS2;
            ackSeen   <= next_ackSeen;
        end
    end

    // ****************************************************************
    // Link side
    // ****************************************************************
    link_serializer u_link
    (
        .linkClk      (linkClk),
        .arst_n       (arst_n),
        .bitReqToggle (reqToggle),
        .bitData      (bitData),
        .bitLast      (bitLast),
        .bitAckToggle (ackToggle),
        .driverSck    (driverSck),
        .driverSdo    (driverSdo),
        .driverCsN    (driverCsN)
    );
endmodule

/* test/dcd_props.sv */
// Concurrent checks on the ports of the datagram RAM block
`timescale 1ns/1ps
module dcd_props
(
    input wire logic                                  mclk,      // System clock
    input wire logic                                  arst_n,    // Async reset, active low
    input wire logic                                  linkClk,   // Link clock
    input wire logic [dcd_pkg::BUS_AW-1:0]            addr,      // Bus address
    input wire logic [dcd_pkg::DATA_W-1:0]            wdata,     // Write data
    input wire logic                                  wr,        // Write strobe
    input wire logic                                  rd,        // Read strobe
    input wire logic [dcd_pkg::DATA_W-1:0]            rdata,     // Read data
    input wire logic                                  sendReq,   // Datagram demand
    input dcd_pkg::motor_in_t [dcd_pkg::NUM_MOTORS-1:0] motorIn, // Sequencer inputs
    input wire logic                                  busy,      // Frame in progress
    input wire logic                                  driverSck, // Chain clock
    input wire logic                                  driverSdo, // Chain data
    input wire logic                                  driverCsN  // Chain select
);
    import dcd_pkg::*;
    rdata_idle_a: assert property (@(posedge mclk) disable iff (!arst_n)
        !$past(rd) |-> rdata == 0) else $error("read data outside its slot");
    unmapped_reg_a: assert property (@(posedge mclk) disable iff (!arst_n)
        rd && !addr[6] && addr[5:0] > 6'h01 |=> rdata == 0) else $error("unmapped register not zero");
    busy_start_a: assert property (@(posedge mclk) disable iff (!arst_n)
        !busy && sendReq |=> busy) else $error("demand did not start a frame");
    on_demand_a: assert property (@(posedge mclk) disable iff (!arst_n)
        $rose(busy) |-> $past(sendReq) || $past(wr)) else $error("frame without demand");
    sck_frame_a: assert property (@(posedge linkClk) disable iff (!arst_n)
        driverSck |-> !driverCsN) else $error("clock outside frame");
    sck_pulse_a: assert property (@(posedge linkClk) disable iff (!arst_n)
        driverSck |=> !driverSck) else $error("clock high too long");
    sdo_hold_a: assert property (@(posedge linkClk) disable iff (!arst_n)
        driverSck |-> $stable(driverSdo)) else $error("data moved under clock");
    cs_end_a: assert property (@(posedge linkClk) disable iff (!arst_n)
        $rose(driverCsN) |-> $fell(driverSck)) else $error("frame end misplaced");
    cs_start_a: assert property (@(posedge linkClk) disable iff (!arst_n)
        $fell(driverCsN) |-> !driverSck) else $error("frame start misplaced");
    cover property (@(posedge mclk) !busy && sendReq);
    cover property (@(posedge mclk) rd && addr[6]);
    cover property (@(posedge linkClk) $rose(driverCsN));
endmodule
bind driver_chain_datagram_ram dcd_props chk_u (.mclk, .arst_n, .linkClk, .addr, .wdata, .wr, .rd, .rdata,
    .sendReq, .motorIn, .busy, .driverSck, .driverSdo, .driverCsN);

/* test/chain_model.sv */
// Far-side model: daisy chain of drivers capturing the serial frame
`timescale 1ns/1ps
module chain_model
(
    input wire logic driverSck, // Chain clock
    input wire logic driverCsN, // Chain select
    input wire logic driverSdo  // Chain data
);
    // First captured bit ends up in the far-end driver, motor zero
    logic bits[$];
    always @(posedge driverSck)
        if (!driverCsN)
            bits.push_back(driverSdo);
endmodule

/* test/tb_top.sv */
// Self-checking bench for the datagram RAM block
`timescale 1ns/1ps
module tb_top;
    import dcd_pkg::*;
    logic mclk = 0, linkClk = 0, arst_n = 0, wr = 0, rd = 0, sendReq = 0;
    logic [6:0] addr = 0;
    logic [11:0] wdata = 0, rdata, d;
    logic busy, driverSck, driverSdo, driverCsN;
    motor_in_t [NUM_MOTORS-1:0] motorIn = '0;
    logic [5:0] cells[128];
    logic exq[$];
    integer seed = 71592, n_errors = 0, checks = 0, cyc = 0, i;
    driver_chain_datagram_ram dut_u (.mclk, .arst_n, .linkClk, .addr, .wdata, .wr, .rd, .rdata, .sendReq,
        .motorIn, .busy, .driverSck, .driverSdo, .driverCsN);
    chain_model chain_u (.driverSck, .driverCsN, .driverSdo);
    initial forever #10 mclk = ~mclk;
    initial begin #7; forever #40 linkClk = ~linkClk; end
    // Hang guard: every scenario together stays far below this
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc > 30000)
        begin
            n_errors++;
            summarize();
        end
    end
    task summarize;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input logic [11:0] seen, input logic [11:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wrBus(input logic [6:0] a, input logic [11:0] v);
        @(posedge mclk);
        addr <= a;
        wdata <= v;
        wr <= 1;
        @(posedge mclk);
        wr <= 0;
    endtask
    task rdBus(input logic [6:0] a);
        @(posedge mclk);
        addr <= a;
        rd <= 1;
        @(posedge mclk);
        rd <= 0;
        #1 d = rdata;
    endtask
    function automatic logic [5:0] tab(input logic [7:0] p);
        return cells[64 + (p[6] ? 63 - p[5:0] : p[5:0])];
    endfunction
    // Value of one selector code for one motor, from the snapshot inputs
    function automatic logic expBit(input int m, input logic [4:0] c);
        logic [7:0] pa, pb;
        logic [5:0] ta, tb;
        if (m > 2) return 0;
        pa = motorIn[m].microstep << motorIn[m].resolution;
        pb = pa + 8'h40;
        ta = tab(pa);
        tb = tab(pb);
        case (c) inside
            [5'h00:5'h05]: return ta[c];
            5'h06: return pa[7];
            5'h07: return motorIn[m].fastDecayA;
            [5'h08:5'h0D]: return tb[c - 8];
            5'h0E: return pb[7];
            5'h0F: return motorIn[m].fastDecayB;
            5'h11: return 1;
            5'h12: return motorIn[m].direction;
            5'h13: return motorIn[m].step;
            default: return 0;
        endcase
    endfunction
    task frame(input int ldi, input bit viaReg);
        int m, p;
        m = 0;
        p = 0;
        exq = {};
        chain_u.bits = {};
        @(posedge mclk);
        motorIn <= 45'({$random(seed), $random(seed)});
        @(posedge mclk);
        while (1)
        begin
            exq.push_back(expBit(m, cells[p][4:0]));
            if (cells[p][5])
            begin
                if (m == ldi) break;
                m++;
            end
            p++;
        end
        if (viaReg)
            wrBus(7'h00, 12'(4 + ldi));
        else
        begin
            sendReq <= 1;
            @(posedge mclk);
            sendReq <= 0;
            #1 chk(busy, 1);
        end
        repeat (60) @(posedge mclk);
        sendReq <= 1;
        @(posedge mclk);
        sendReq <= 0;
        for (i = 0; i < 8000 && busy !== 0; i++) @(posedge mclk);
        repeat (40) @(posedge mclk);
        chk(chain_u.bits.size(), exq.size());
        foreach (exq[k]) chk(chain_u.bits[k], exq[k]);
    endtask
    initial
    begin
        repeat (8) @(posedge mclk);
        arst_n <= 1;
        rdBus(7'h00);
        chk(d, 12'h002);
        for (int a = 0; a < 64; a++)
        begin
            d = $random(seed);
            if (a < 4) d = {6'h32, 6'h23} ^ {(a == 0) ? 12'h2CE : (a == 2) ? 12'h18C : (a == 3) ? 12'h02B : 12'h0};
            wrBus({1'b1, 6'(a)}, d);
            {cells[2 * a + 1], cells[2 * a]} = d;
        end
        cells[1] = 6'h10;
        cells[0] = 6'h11;
        wrBus(7'h40, {cells[1], cells[0]});
        for (int a = 0; a < 64; a++)
        begin
            rdBus({1'b1, 6'(a)});
            chk(d, {cells[2 * a + 1], cells[2 * a]});
        end
        repeat (4)
        begin
            rdBus({1'b0, 6'(2 + ({$random(seed)} % 62))});
            chk(d, 0);
        end
        frame(2, 0);
        frame(1, 1);
        rdBus(7'h01);
        chk({9'h0, d[2:0]}, 0);
        summarize();
    end
endmodule
